// [include/rcm_pkg.sv]
// Package for the reset and clock manager: register map, option fields, timing counts.
// Assumes a single 20 MHz sys_clk and a plain strobe register port.
package rcm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] RCM_ADDR_STATUS = 4'h0;
    localparam logic [3:0] RCM_ADDR_OPTION = 4'h1;
    localparam logic [3:0] RCM_ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] RCM_ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] RCM_ADDR_PHASE = 4'h4;

    localparam int RCM_WDG_FLAG_BIT = 0;
    localparam logic [7:0] RCM_STATUS_RESET = 8'h00;
    localparam logic [7:0] RCM_OPTION_RESET = 8'h00;
    localparam logic [7:0] RCM_MASK_RESET = 8'h00;

    // Option byte fields.
    localparam int RCM_OPT_PLL_BIT = 0;
    localparam int RCM_OPT_LONG_BIT = 1;
    localparam int RCM_OPT_SRC_LSB = 2;

    // Interrupt event bits.
    localparam int RCM_EV_EXT_BIT = 0;
    localparam int RCM_EV_WDG_BIT = 1;
    localparam int RCM_EV_DONE_BIT = 2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int RCM_DELAY_SHORT = 256;
    localparam int RCM_DELAY_LONG = 4096;
    localparam int RCM_FETCH_CYCLES = 2;
    localparam int RCM_CLK_PERIOD_NS = 50;
    localparam int RCM_WDG_PULSE_NS = 30000;
    localparam int RCM_WDG_PULSE_CYC =
        (RCM_WDG_PULSE_NS + RCM_CLK_PERIOD_NS - 1) / RCM_CLK_PERIOD_NS;
    localparam logic [15:0] RCM_RESET_VECTOR = 16'hfffe;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RCM_SRC_EXT = 2'h0,
        RCM_SRC_LOW = 2'h1,
        RCM_SRC_MID = 2'h2,
        RCM_SRC_HIGH = 2'h3
    } rcm_src_e;

    // Resonator range "4" lives in the extra encoding bit below.
    typedef struct packed {
        logic [2:0] src;
        logic long_delay;
        logic pll_en;
    } rcm_option_s;

    typedef enum logic [1:0] {
        RCM_ST_ACTIVE = 2'b00,
        RCM_ST_DELAY = 2'b01,
        RCM_ST_FETCH = 2'b11,
        RCM_ST_RUN = 2'b10
    } rcm_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rcm_bus_s;

endpackage

// [rtl/rcm_sync.sv]
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module rcm_sync import rcm_pkg::*; #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [rtl/rcm_clkgen.sv]
// Internal core clock enable: doubled oscillator with the PLL, halved without it.
// Assumes the oscillator clock is sampled as a synchronised level.
`timescale 1ns/1ps
module rcm_clkgen import rcm_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic osc_level,
    input wire logic pll_en,
    output logic core_tick
);
    logic osc_prev_q;
    logic half_q;
    logic edge_any;

    assign edge_any = osc_level ^ osc_prev_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            osc_prev_q <= 1'b0;
            half_q <= 1'b0;
            core_tick <= 1'b0;
        end else begin
            osc_prev_q <= osc_level;
            // Every oscillator edge is a core tick when doubled.
            if (pll_en) begin
                core_tick <= edge_any;
            end else begin
                // One tick each two rising edges divides by two.
                if (edge_any && osc_level) begin
                    half_q <= ~half_q;
                end
                core_tick <= edge_any && osc_level && half_q;
            end
        end
    end
endmodule

// [rtl/rcm_top.sv]
// Reset sequence manager and main clock selection with status and interrupt.
// Assumes a 20 MHz sys_clk, an open-drain reset pin resolved outside, and a strobe bus.
//
// Notes on behaviour
// - With PLL on and 2-4 MHz input, core clock is doubled.
// - PLL enabled by option byte; otherwise core clock is oscillator over two.
// - Option byte picks external clock or one of four resonator ranges.
// - Resonator keeps running while reset is asserted.
// - External pin and watchdog both reset; pin held low through delay.
// - After delay, fetch reset vector from the top two addresses.
// - Reset runs active, delay, then vector fetch, in order.
// - Delay is 256 or 4096 cycles, chosen by option byte.
// - Vector fetch takes exactly two cycles before normal running.
// - Reset pin is input and open-drain output with weak pull-up.
// - External low pulse is caught without a running clock.
// - Watchdog underflow drives pin low at least minimum output width.
// - Watchdog reset sets flag bit 0; software clears by writing zero.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module rcm_top import rcm_pkg::*; #(
    parameter int DELAY_SHORT = RCM_DELAY_SHORT,
    parameter int DELAY_LONG = RCM_DELAY_LONG,
    parameter int WDG_PULSE = RCM_WDG_PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reset_pin_in,
    output logic reset_pin_oe,
    output logic reset_pin_out,
    input wire logic wdg_underflow,
    input wire logic oscillator_input_pin,
    output logic oscillator_enable,
    output logic [2:0] osc_range_sel,
    output logic core_tick_q,
    output logic cpu_reset_b,
    output logic [15:0] fetch_addr,
    output logic fetch_valid,
    input wire rcm_bus_s bus,
    output logic [7:0] rdata,
    output logic irq
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    initial begin
        if (DELAY_SHORT < 1 || DELAY_LONG < DELAY_SHORT || DELAY_LONG > 65535 ||
            WDG_PULSE < 1 || WDG_PULSE > 65535) begin
            $error("rcm_top: unsupported delay parameters.");
        end
    end

    localparam logic [15:0] SHORT_TOP = 16'(DELAY_SHORT - 1);
    localparam logic [15:0] LONG_TOP = 16'(DELAY_LONG - 1);
    localparam logic [15:0] PULSE_TOP = 16'(WDG_PULSE - 1);
    localparam logic [1:0] FETCH_TOP = 2'(RCM_FETCH_CYCLES - 1);

    // ----------------------------------------------------------------
    // Input capture
    // ----------------------------------------------------------------
    logic pin_async_low_q;
    logic pin_low_sync;
    logic osc_sync;
    logic core_tick;
    rcm_state_e state_q;
    rcm_option_s opt_q;

    // The pin low is latched without a clock edge, so a halted clock still catches it.
    // The latch is released once the synchronised pin is seen high again.
    // While the device drives the pin itself the latch is held clear.
    logic pin_clear_q;
    logic pin_clear;
    logic pin_high_sync;
    assign pin_clear = pin_clear_q | reset_pin_oe;
    always_ff @(negedge reset_pin_in or posedge pin_clear) begin
        if (pin_clear) begin
            pin_async_low_q <= 1'b0;
        end else begin
            pin_async_low_q <= 1'b1;
        end
    end

    rcm_sync #(.RESET_VAL(1'b1)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(pin_async_low_q | ~reset_pin_in),
        .sync_out(pin_low_sync)
    );

    rcm_sync #(.RESET_VAL(1'b0)) u_pin_high_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(reset_pin_in),
        .sync_out(pin_high_sync)
    );

    rcm_sync #(.RESET_VAL(1'b0)) u_osc_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(oscillator_input_pin),
        .sync_out(osc_sync)
    );

    rcm_clkgen u_clkgen (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .osc_level(osc_sync),
        .pll_en(opt_q.pll_en),
        .core_tick(core_tick)
    );

    // ----------------------------------------------------------------
    // Option byte and clock selection
    // ----------------------------------------------------------------
    // The synchroniser still shows the pin low for two cycles after the device lets go.
    logic ext_low;
    logic [1:0] oe_hist_q;
    assign ext_low = pin_low_sync & ~reset_pin_oe & ~(|oe_hist_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            oe_hist_q <= 2'b11;
        end else begin
            oe_hist_q <= {oe_hist_q[0], reset_pin_oe};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_clear_q <= 1'b0;
        end else begin
            pin_clear_q <= pin_async_low_q & pin_low_sync & pin_high_sync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            opt_q <= rcm_option_s'(RCM_OPTION_RESET[4:0]);
        end else if (bus.wr && bus.addr == RCM_ADDR_OPTION) begin
            opt_q <= rcm_option_s'(bus.wdata[4:0]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            oscillator_enable <= 1'b1;
            osc_range_sel <= 3'h0;
            core_tick_q <= 1'b0;
        end else begin
            // Resonator stays on in every phase, reset included.
            oscillator_enable <= (opt_q.src != 3'(RCM_SRC_EXT));
            osc_range_sel <= opt_q.src;
            core_tick_q <= core_tick;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    logic [15:0] cnt_q;
    logic [15:0] pulse_q;
    logic wdg_req;
    logic src_active;
    logic [15:0] delay_top;

    assign wdg_req = wdg_underflow;
    assign src_active = ext_low | wdg_req | (pulse_q != 16'h0000);
    assign delay_top = opt_q.long_delay ? LONG_TOP : SHORT_TOP;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pulse_q <= 16'h0000;
        end else if (wdg_req) begin
            pulse_q <= PULSE_TOP + 16'h0001;
        end else if (pulse_q != 16'h0000) begin
            pulse_q <= pulse_q - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= RCM_ST_ACTIVE;
            cnt_q <= 16'h0000;
        end else if (src_active) begin
            // Any source restarts the whole sequence.
            state_q <= RCM_ST_ACTIVE;
            cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                RCM_ST_ACTIVE: begin
                    state_q <= RCM_ST_DELAY;
                    cnt_q <= 16'h0000;
                end
                RCM_ST_DELAY: begin
                    if (cnt_q == delay_top) begin
                        state_q <= RCM_ST_FETCH;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                RCM_ST_FETCH: begin
                    if (cnt_q[1:0] == FETCH_TOP) begin
                        state_q <= RCM_ST_RUN;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                RCM_ST_RUN: begin
                    state_q <= RCM_ST_RUN;
                end
                default: begin
                    state_q <= RCM_ST_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reset_pin_oe <= 1'b1;
            reset_pin_out <= 1'b0;
            cpu_reset_b <= 1'b0;
            fetch_addr <= 16'h0000;
            fetch_valid <= 1'b0;
        end else begin
            // Pin driven low in active and delay phases from either source.
            reset_pin_oe <= wdg_req | (pulse_q > 16'h0001) |
                ((state_q == RCM_ST_DELAY || state_q == RCM_ST_ACTIVE) && !ext_low);
            reset_pin_out <= 1'b0;
            cpu_reset_b <= (state_q == RCM_ST_RUN) && !src_active;
            fetch_valid <= (state_q == RCM_ST_FETCH) && !src_active;
            // Vector bytes come from the top two addresses.
            fetch_addr <= RCM_RESET_VECTOR | {15'h0000, cnt_q[0]};
        end
    end

    // ----------------------------------------------------------------
    // Registers and interrupt
    // ----------------------------------------------------------------
    logic wdg_flag_q;
    logic [2:0] ev_q;
    logic [2:0] mask_q;
    logic [2:0] ev_set;
    logic ext_low_prev_q;
    logic done_ev;

    assign done_ev = (state_q == RCM_ST_FETCH) && (cnt_q[1:0] == FETCH_TOP) && !src_active;
    assign ev_set = {done_ev, wdg_req, ext_low & ~ext_low_prev_q};

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wdg_flag_q <= RCM_STATUS_RESET[RCM_WDG_FLAG_BIT];
        end else if (wdg_req) begin
            wdg_flag_q <= 1'b1;
        end else if (bus.wr && bus.addr == RCM_ADDR_STATUS &&
                     !bus.wdata[RCM_WDG_FLAG_BIT]) begin
            wdg_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ev_q <= 3'h0;
            ext_low_prev_q <= 1'b0;
            mask_q <= RCM_MASK_RESET[2:0];
            irq <= 1'b0;
        end else begin
            ext_low_prev_q <= ext_low;
            if (bus.rd && bus.addr == RCM_ADDR_IRQ_STATUS) begin
                ev_q <= ev_set;
            end else begin
                ev_q <= ev_q | ev_set;
            end
            if (bus.wr && bus.addr == RCM_ADDR_IRQ_MASK) begin
                mask_q <= bus.wdata[2:0];
            end
            irq <= |(ev_q & mask_q);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                RCM_ADDR_STATUS: rdata <= {7'h00, wdg_flag_q};
                RCM_ADDR_OPTION: rdata <= {3'h0, opt_q};
                RCM_ADDR_IRQ_STATUS: rdata <= {5'h00, ev_q};
                RCM_ADDR_IRQ_MASK: rdata <= {5'h00, mask_q};
                RCM_ADDR_PHASE: rdata <= {6'h00, state_q};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_WDG_PIN_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wdg_req |=> reset_pin_oe [*2])
        else $error("Watchdog reset did not drive the pin low.");

    AST_WDG_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wdg_req |=> wdg_flag_q)
        else $error("Watchdog flag not set.");

    AST_FETCH_TWO: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == RCM_ST_DELAY) ##1 (state_q == RCM_ST_FETCH) && !src_active
        |=> (state_q == RCM_ST_FETCH) ##1 (state_q == RCM_ST_RUN || $past(src_active)))
        else $error("Vector fetch did not last two cycles.");

    AST_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == RCM_ST_FETCH) |-> $past(state_q) inside {RCM_ST_DELAY, RCM_ST_FETCH})
        else $error("Fetch entered out of order.");

    AST_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_b)
        src_active |=> state_q == RCM_ST_ACTIVE)
        else $error("New source did not restart the sequence.");

    AST_DELAY_PIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == RCM_ST_DELAY) && !ext_low |=> reset_pin_oe && !reset_pin_out)
        else $error("Pin released during delay.");

    AST_DELAY_LEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == RCM_ST_FETCH) && $past(state_q) == RCM_ST_DELAY
        |-> $past(cnt_q) == $past(delay_top))
        else $error("Delay length differs from option.");

    AST_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fetch_valid |-> fetch_addr[15:1] == RCM_RESET_VECTOR[15:1])
        else $error("Fetch outside reset vector.");

    AST_OSC_ON: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (opt_q.src != 3'(RCM_SRC_EXT)) && !cpu_reset_b ##1 1'b1 |-> oscillator_enable)
        else $error("Resonator stopped during reset.");

    AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus.wr && bus.addr == RCM_ADDR_STATUS && !bus.wdata[RCM_WDG_FLAG_BIT] && !wdg_req
        |=> !wdg_flag_q)
        else $error("Watchdog flag not cleared by a zero write.");

    AST_PIN_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state_q == RCM_ST_RUN) && !src_active |=> !reset_pin_oe)
        else $error("Pin still driven while running.");

endmodule

// [testbench/rcm_partner.sv]
// Far-side model: the external reset circuit on the open-drain pin and the watchdog counter.
// Assumes the bench calls its tasks from one process, aligned to sys_clk.
`timescale 1ns/1ps
module rcm_partner import rcm_pkg::*; (
    input wire logic sys_clk,
    input wire logic pin_oe,
    output logic pin_level,
    output logic wdg_underflow
);
    // ----------------------------------------------------------------
    // Pin and pulses
    // ----------------------------------------------------------------
    logic ext_low;
    initial begin
        ext_low = 1'b0;
        wdg_underflow = 1'b0;
    end
    // The wire has a weak pull-up and is low while either party pulls it.
    assign pin_level = ~(pin_oe | ext_low);
    // The pin is held low for whole cycles, above the minimum width.
    task automatic ext_pulse(input int cycles);
        @(posedge sys_clk);
        ext_low <= 1'b1;
        repeat (cycles) @(posedge sys_clk);
        ext_low <= 1'b0;
    endtask
    // A short low pulse placed between two rising clock edges.
    task automatic ext_glitch();
        @(posedge sys_clk);
        #10 ext_low = 1'b1;
        #20 ext_low = 1'b0;
    endtask
    // One-cycle underflow pulse of the watchdog counter.
    task automatic wdg_pulse();
        @(posedge sys_clk);
        wdg_underflow <= 1'b1;
        @(posedge sys_clk);
        wdg_underflow <= 1'b0;
    endtask
endmodule

// [testbench/tb_rcm_top.sv]
// Self-checking bench for the reset and clock manager.
// Assumes small delay parameters and a 2 MHz oscillator made here.
`timescale 1ns/1ps
module tb_rcm_top import rcm_pkg::*; ;
    localparam int DS = 4;
    localparam int DL = 8;
    localparam int WP = 2;
    localparam int TMAX = 20000;
    logic sys_clk = 1'b0;
    logic rst_b, osc, oe, wdg, osc_en, ctick, cpu_rb, fvalid, irq, pin;
    logic [2:0] rsel;
    logic [15:0] faddr;
    logic [7:0] rdata;
    rcm_bus_s bus;
    logic rd_d = 1'b0;
    logic [8:0] exp_r;
    logic [8:0] expq[$];
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int fidx = 0;

    always #25 sys_clk = ~sys_clk;
    initial begin
        osc = 1'b0;
        #37;
        forever #250 osc = ~osc;
    end

    rcm_top #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WDG_PULSE(WP)) u_rcm_top (
        .sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_in(pin), .reset_pin_oe(oe),
        .reset_pin_out(), .wdg_underflow(wdg), .oscillator_input_pin(osc),
        .oscillator_enable(osc_en), .osc_range_sel(rsel), .core_tick_q(ctick),
        .cpu_reset_b(cpu_rb), .fetch_addr(faddr), .fetch_valid(fvalid), .bus(bus),
        .rdata(rdata), .irq(irq));
    rcm_partner u_rcm_partner (.sys_clk(sys_clk), .pin_oe(oe), .pin_level(pin),
        .wdg_underflow(wdg));

    // ----------------------------------------------------------------
    // Compare, report and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    // Bit 8 of the note set means the data are not compared.
    task automatic rd(input logic [3:0] a, input logic [8:0] e);
        @(posedge sys_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        expq.push_back(e);
        @(posedge sys_clk);
        bus <= '0;
    endtask
    // Counts cycles until the pin is let go, then the fetch phase.
    task automatic seq_wait(output int n);
        int m;
        logic bad;
        n = 0;
        m = 0;
        bad = 1'b0;
        while (oe !== 1'b0 && n < 2000) begin
            if (cpu_rb !== 1'b0 || osc_en !== 1'b1) bad = 1'b1;
            @(negedge sys_clk);
            n++;
        end
        chk(!bad, "core held, oscillator running");
        while (cpu_rb !== 1'b1 && m < 10) begin
            @(negedge sys_clk);
            m++;
        end
        chk(m == RCM_FETCH_CYCLES, "fetch phase length");
    endtask
    // The device takes the pin over only once the outside circuit has let go.
    task automatic ext_seq(output int n);
        int t;
        u_rcm_partner.ext_pulse(5 + $urandom_range(7));
        t = 0;
        while (oe !== 1'b1 && t < 10) begin
            @(negedge sys_clk);
            t++;
        end
        chk(oe === 1'b1 && pin === 1'b0, "pin held by device");
        seq_wait(n);
    endtask

    // ----------------------------------------------------------------
    // Watchers
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == TMAX) begin
            errors++;
            wrap_up();
        end
    end
    always @(posedge sys_clk) begin
        if (rd_d && expq.size() > 0) begin
            exp_r = expq.pop_front();
            if (!exp_r[8]) chk8(rdata, exp_r[7:0]);
        end
        rd_d <= bus.rd;
        if (fvalid === 1'b1) begin
            chk(faddr === RCM_RESET_VECTOR + 16'(fidx), "fetch address");
            fidx++;
        end else if (fidx != 0) begin
            chk(fidx == 2, "fetch length");
            fidx = 0;
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        int n1, n2, n, t;
        rst_b = 1'b0;
        bus = '0;
        void'($urandom(32'h0362679d));
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(oe === 1'b1 && cpu_rb === 1'b0, "reset outputs");
        @(posedge sys_clk);
        rst_b <= 1'b1;
        t = 0;
        while (cpu_rb !== 1'b1 && t < 100) begin
            @(negedge sys_clk);
            t++;
        end
        chk(cpu_rb === 1'b1, "core released");
        rd(RCM_ADDR_STATUS, {1'b0, RCM_STATUS_RESET});
        rd(RCM_ADDR_OPTION, {1'b0, RCM_OPTION_RESET});
        rd(RCM_ADDR_IRQ_MASK, {1'b0, RCM_MASK_RESET});
        rd(RCM_ADDR_PHASE, {1'b0, 6'h00, RCM_ST_RUN});
        rd(4'hf, 9'h000);
        rd(RCM_ADDR_IRQ_STATUS, 9'h100);
        $display("test reset_defaults done");
        for (int s = 0; s < 5; s++) begin
            wr(RCM_ADDR_OPTION, 8'(s << RCM_OPT_SRC_LSB));
            repeat (2) @(negedge sys_clk);
            chk(rsel === 3'(s) && osc_en === (s != 0), "source select");
            rd(RCM_ADDR_OPTION, {1'b0, 8'(s << RCM_OPT_SRC_LSB)});
        end
        $display("test source_select done");
        for (int p = 1; p >= 0; p--) begin
            wr(RCM_ADDR_OPTION, 8'h04 | 8'(p));
            repeat (20) @(posedge sys_clk);
            n = 0;
            repeat (400) begin
                @(negedge sys_clk);
                n += (ctick === 1'b1);
            end
            chk(n >= (p ? 78 : 18) && n <= (p ? 82 : 22), "core rate");
        end
        $display("test core_clock done");
        wr(RCM_ADDR_IRQ_MASK, 8'h02);
        wr(RCM_ADDR_OPTION, 8'h08);
        u_rcm_partner.wdg_pulse();
        repeat (2) @(negedge sys_clk);
        chk(oe === 1'b1 && pin === 1'b0, "watchdog drives pin");
        seq_wait(n);
        chk(n + 2 >= WP + DS, "watchdog low width");
        chk(irq === 1'b1, "interrupt raised");
        rd(RCM_ADDR_STATUS, 9'h001);
        rd(RCM_ADDR_IRQ_STATUS, 9'h006);
        repeat (3) @(negedge sys_clk);
        chk(irq === 1'b0, "interrupt cleared by read");
        wr(RCM_ADDR_STATUS, 8'h01);
        rd(RCM_ADDR_STATUS, 9'h001);
        wr(RCM_ADDR_STATUS, 8'h00);
        rd(RCM_ADDR_STATUS, 9'h000);
        $display("test watchdog_reset done");
        wr(RCM_ADDR_OPTION, 8'h04);
        ext_seq(n1);
        wr(RCM_ADDR_OPTION, 8'h06);
        ext_seq(n2);
        chk(n2 - n1 == DL - DS, "delay option");
        rd(RCM_ADDR_STATUS, 9'h000);
        rd(RCM_ADDR_IRQ_STATUS, 9'h005);
        $display("test external_reset done");
        u_rcm_partner.ext_glitch();
        repeat (8) @(negedge sys_clk);
        chk(oe === 1'b1, "short pin pulse caught");
        seq_wait(n);
        $display("test async_pulse done");
        u_rcm_partner.ext_pulse(6);
        t = 0;
        while (oe !== 1'b1 && t < 20) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (3) @(posedge sys_clk);
        u_rcm_partner.wdg_pulse();
        seq_wait(n);
        chk(n >= WP + DL, "restart on new source");
        rd(RCM_ADDR_STATUS, 9'h001);
        repeat (3) @(posedge sys_clk);
        $display("test restart done");
        wrap_up();
    end
endmodule
